// ---- include/dpm_pkg.sv ----
// package for the dual port alternate function mux
package dpm_pkg;
  localparam int PORT_W = 8;
  localparam logic [7:0] LATCH_RST = 8'hFF;
  // serial/strobe port pin positions
  localparam int SP_RX = 0;
  localparam int SP_TX = 1;
  localparam int SP_IRQ0 = 2;
  localparam int SP_IRQ1 = 3;
  localparam int SP_CNT0 = 4;
  localparam int SP_CNT1 = 5;
  localparam int SP_WR = 6;
  localparam int SP_RD = 7;
  // capture/compare port channel count and pin positions
  localparam int CC_CH_N = 5;
  localparam int CC_RELOAD = 5;
  localparam int CC_SYSTEM_CLOCK_OUTPUT = 6;
  localparam int CC_CNT2 = 7;

  typedef struct packed {
    logic [7:0] s0;
    logic [7:0] s1;
    logic [7:0] s2;
  } dpm_sync_t;

  typedef struct packed {
    logic [7:0] latch;
    logic [7:0] drive_low;
    logic [7:0] strong_oe;
    logic [7:0] in_level;
  } dpm_port_t;

  typedef struct packed {
    dpm_sync_t sp_sync;
    dpm_sync_t cc_sync;
    dpm_port_t sp;
    dpm_port_t cc;
    logic serial_zero_receive;
    logic ext_irq0;
    logic ext_irq1;
    logic counter_zero_input;
    logic counter_one_input;
    logic [4:0] cc_irq_in;
    logic [4:0] cc_capture_in;
    logic timer_two_reload_trigger;
    logic counter_two_input;
    logic serial_sync_data_in;
  } dpm_state_t;
endpackage : dpm_pkg

// ---- hw/dpm_mux.sv ----
// two eight-bit quasi-bidirectional ports with alternate function muxing
// Contract
// - latch one: weak pull-up only, input; sp drives strong high for the first cycle after a zero-to-one write
// - serial port functions need latch one
// - pin0 receive/sync data, pin1 transmit/clock
// - pins 2,3 interrupts and timer gates
// - pins 4,5 counter zero/one inputs
// - pins 6,7 write and read strobes
// - verify mode: low address byte out
// - cc inputs need latch one; compares override
// - pins 0-4 interrupt, compare, capture
// - pin5 timer two reload trigger
// - pin6 may output system clock
// - pin7 counter two input
module dpm_mux (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // core latch writes
  input wire logic sp_latch_we,
  input wire logic [7:0] sp_latch_wdata,
  input wire logic cc_latch_we,
  input wire logic [7:0] cc_latch_wdata,
  // serial/strobe port alternate outputs (low means pull pin low)
  input wire logic serial_zero_transmit,
  input wire logic serial_sync_mode,
  input wire logic serial_sync_data_oe,
  input wire logic serial_sync_data_out,
  input wire logic mem_write_strobe_b,
  input wire logic mem_read_strobe_b,
  // capture/compare port alternate outputs
  input wire logic [4:0] compare_en,
  input wire logic [4:0] compare_out,
  input wire logic system_clock_output_en,
  input wire logic system_clock_output,
  input wire logic verify_mode,
  input wire logic [7:0] verify_addr_lo,
  // pins
  input wire logic [7:0] sp_pin_in,
  output logic [7:0] sp_pin_out,
  output logic [7:0] sp_pin_oe,
  output logic [7:0] sp_pin_pullup,
  input wire logic [7:0] cc_pin_in,
  output logic [7:0] cc_pin_out,
  output logic [7:0] cc_pin_oe,
  output logic [7:0] cc_pin_pullup,
  // pin reads and alternate inputs to the core
  output logic [7:0] sp_pin_read,
  output logic [7:0] cc_pin_read,
  output logic [7:0] sp_latch,
  output logic [7:0] cc_latch,
  output logic serial_zero_receive,
  output logic serial_sync_data_in,
  output logic ext_irq0,
  output logic ext_irq1,
  output logic counter_zero_input,
  output logic counter_one_input,
  output logic [4:0] cc_irq_in,
  output logic [4:0] cc_capture_in,
  output logic timer_two_reload_trigger,
  output logic counter_two_input
);
  dpm_pkg::dpm_state_t st;
  dpm_pkg::dpm_state_t next_st;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic [7:0] sp_lat;
    logic [7:0] cc_lat;
    logic [7:0] sp_alt;
    logic [7:0] cc_alt;
    logic [7:0] sp_in;
    logic [7:0] cc_in;
    sp_lat = '0;
    cc_lat = '0;
    sp_alt = '1;
    cc_alt = '1;
    sp_in = '0;
    cc_in = '0;
    next_st = st;
    // three stage sampling; a change counts when stages two and three agree
    // only stage two reads stage one, so a metastable first stage cannot leak
    next_st.sp_sync.s0 = sp_pin_in;
    next_st.sp_sync.s1 = st.sp_sync.s0;
    next_st.sp_sync.s2 = st.sp_sync.s1;
    next_st.cc_sync.s0 = cc_pin_in;
    next_st.cc_sync.s1 = st.cc_sync.s0;
    next_st.cc_sync.s2 = st.cc_sync.s1;
    for (int i = 0; i < dpm_pkg::PORT_W; i++) begin
      if (st.sp_sync.s1[i] == st.sp_sync.s2[i]) begin
        next_st.sp.in_level[i] = st.sp_sync.s2[i];
      end
      if (st.cc_sync.s1[i] == st.cc_sync.s2[i]) begin
        next_st.cc.in_level[i] = st.cc_sync.s2[i];
      end
    end
    sp_in = st.sp.in_level;
    cc_in = st.cc.in_level;
    sp_lat = sp_latch_we ? sp_latch_wdata : st.sp.latch;
    cc_lat = cc_latch_we ? cc_latch_wdata : st.cc.latch;
    next_st.sp.latch = sp_lat;
    next_st.cc.latch = cc_lat;
    // serial/strobe alternate outputs; idle high so only the latch matters
    if (serial_sync_mode) begin
      sp_alt[dpm_pkg::SP_RX] = serial_sync_data_oe ? serial_sync_data_out : 1'b1;
    end
    sp_alt[dpm_pkg::SP_TX] = serial_zero_transmit;
    sp_alt[dpm_pkg::SP_WR] = mem_write_strobe_b;
    sp_alt[dpm_pkg::SP_RD] = mem_read_strobe_b;
    // pin is pulled low when latch or alternate output is zero
    next_st.sp.drive_low = ~(sp_lat & sp_alt);
    // strong high for one cycle after release, to speed the edge
    next_st.sp.strong_oe = sp_lat & ~st.sp.latch;
    // compare outputs override the latch
    for (int c = 0; c < dpm_pkg::CC_CH_N; c++) begin
      if (compare_en[c]) begin
        cc_alt[c] = compare_out[c];
      end
    end
    if (system_clock_output_en) begin
      cc_alt[dpm_pkg::CC_SYSTEM_CLOCK_OUTPUT] = system_clock_output;
    end
    if (verify_mode) begin
      next_st.cc.drive_low = ~verify_addr_lo;
      next_st.cc.strong_oe = verify_addr_lo;
    end else begin
      next_st.cc.drive_low = ~(cc_lat | {3'h0, compare_en}) | ~cc_alt;
      next_st.cc.strong_oe = {3'h0, compare_en & compare_out};
    end
    // alternate inputs gated by latch one
    next_st.serial_zero_receive = sp_in[dpm_pkg::SP_RX] | ~st.sp.latch[dpm_pkg::SP_RX];
    next_st.serial_sync_data_in = sp_in[dpm_pkg::SP_RX] | ~st.sp.latch[dpm_pkg::SP_RX];
    next_st.ext_irq0 = sp_in[dpm_pkg::SP_IRQ0] | ~st.sp.latch[dpm_pkg::SP_IRQ0];
    next_st.ext_irq1 = sp_in[dpm_pkg::SP_IRQ1] | ~st.sp.latch[dpm_pkg::SP_IRQ1];
    next_st.counter_zero_input = sp_in[dpm_pkg::SP_CNT0] & st.sp.latch[dpm_pkg::SP_CNT0];
    next_st.counter_one_input = sp_in[dpm_pkg::SP_CNT1] & st.sp.latch[dpm_pkg::SP_CNT1];
    for (int c = 0; c < dpm_pkg::CC_CH_N; c++) begin
      next_st.cc_irq_in[c] = cc_in[c] | ~st.cc.latch[c];
      next_st.cc_capture_in[c] = cc_in[c] & st.cc.latch[c];
    end
    next_st.timer_two_reload_trigger =
      cc_in[dpm_pkg::CC_RELOAD] & st.cc.latch[dpm_pkg::CC_RELOAD];
    next_st.counter_two_input = cc_in[dpm_pkg::CC_CNT2] & st.cc.latch[dpm_pkg::CC_CNT2];
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
      st.sp.latch <= dpm_pkg::LATCH_RST;
      st.cc.latch <= dpm_pkg::LATCH_RST;
      st.sp.in_level <= '1;
      st.cc.in_level <= '1;
      st.sp_sync <= '1;
      st.cc_sync <= '1;
      st.serial_zero_receive <= 1'b1;
      st.serial_sync_data_in <= 1'b1;
      st.ext_irq0 <= 1'b1;
      st.ext_irq1 <= 1'b1;
      st.cc_irq_in <= '1;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // outputs, all from flip-flops
  // ----------------------------------------
  // weak pull-up on unless driven low; pin value is the low drive or strong high (brief on sp, held for cc compares and verify)
  assign sp_pin_out = st.sp.strong_oe & ~st.sp.drive_low;
  assign sp_pin_oe = st.sp.drive_low | st.sp.strong_oe;
  assign sp_pin_pullup = ~st.sp.drive_low;
  assign cc_pin_out = st.cc.strong_oe & ~st.cc.drive_low;
  assign cc_pin_oe = st.cc.drive_low | st.cc.strong_oe;
  assign cc_pin_pullup = ~st.cc.drive_low;
  assign sp_pin_read = st.sp.in_level;
  assign cc_pin_read = st.cc.in_level;
  assign sp_latch = st.sp.latch;
  assign cc_latch = st.cc.latch;
  assign serial_zero_receive = st.serial_zero_receive;
  assign serial_sync_data_in = st.serial_sync_data_in;
  assign ext_irq0 = st.ext_irq0;
  assign ext_irq1 = st.ext_irq1;
  assign counter_zero_input = st.counter_zero_input;
  assign counter_one_input = st.counter_one_input;
  assign cc_irq_in = st.cc_irq_in;
  assign cc_capture_in = st.cc_capture_in;
  assign timer_two_reload_trigger = st.timer_two_reload_trigger;
  assign counter_two_input = st.counter_two_input;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  AST_LATCH_ONE_NO_LOW: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (sp_latch_we && sp_latch_wdata[dpm_pkg::SP_CNT0]) |=> !sp_pin_oe[dpm_pkg::SP_CNT0]
      || sp_pin_out[dpm_pkg::SP_CNT0])
    else $error("latched one pin driven low");
  AST_LATCH_ZERO_LOW: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (sp_latch_we && !sp_latch_wdata[dpm_pkg::SP_CNT1]) |=> sp_pin_oe[dpm_pkg::SP_CNT1]
      && !sp_pin_out[dpm_pkg::SP_CNT1])
    else $error("latched zero pin not driven low");
  AST_TX_FOLLOWS: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (!serial_zero_transmit && !sp_latch_we) |=> sp_pin_oe[dpm_pkg::SP_TX]
      && !sp_pin_out[dpm_pkg::SP_TX])
    else $error("transmit low not on pin");
  AST_WR_STROBE: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (!mem_write_strobe_b) |=> sp_pin_oe[dpm_pkg::SP_WR] && !sp_pin_out[dpm_pkg::SP_WR])
    else $error("write strobe not driven");
  AST_RD_STROBE: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (!mem_read_strobe_b) |=> sp_pin_oe[dpm_pkg::SP_RD] && !sp_pin_out[dpm_pkg::SP_RD])
    else $error("read strobe not driven");
  AST_VERIFY_ADDR: assert property (@(posedge sys_clk) disable iff (!rst_b)
    verify_mode |=> (cc_pin_oe == 8'hFF) && (cc_pin_out == $past(verify_addr_lo)))
    else $error("verify address not on port");
  AST_COMPARE_OVERRIDE: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (compare_en[0] && !verify_mode) |=> cc_pin_oe[0]
      && (cc_pin_out[0] == $past(compare_out[0])))
    else $error("compare output not driven");
  AST_IRQ_GATED: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !cc_latch[1] |=> cc_irq_in[1])
    else $error("interrupt input not gated by latch");
  AST_CNT2_GATED: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !cc_latch[dpm_pkg::CC_CNT2] |=> !counter_two_input)
    else $error("counter two input not gated");
  AST_SYSTEM_CLOCK_OUTPUT: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (system_clock_output_en && !system_clock_output && !verify_mode) |=> cc_pin_oe[dpm_pkg::CC_SYSTEM_CLOCK_OUTPUT])
    else $error("clock output low not driven");
endmodule : dpm_mux

// ---- testbench/dpm_board.sv ----
// board model: resolves one quasi-bidirectional port against external pull-downs
module dpm_board (
  // clock
  input wire logic sys_clk,
  // device side
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pin_pullup,
  // board side
  input wire logic [7:0] ext_low,
  output logic [7:0] pin_level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] last = 8'h00;
  // a line nobody holds wanders, so it never settles kindly
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin_level[i] = pin_oe[i] ? pin_out[i] : ext_low[i] ? 1'b0 : pin_pullup[i] ? 1'b1 : ~last[i];
    end
  end
  always_ff @(posedge sys_clk) last <= pin_level;
endmodule : dpm_board

// ---- testbench/test_dual_port_alt_function_mux.sv ----
// self-checking bench for the dual port alternate function mux
module test_dual_port_alt_function_mux;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, rst_b, sp_we, cc_we, tx, smode, soe, sout, wr_b, rd_b, clk_en, sclk, vmode;
  logic [7:0] sp_wd, cc_wd, vaddr, sp_ext, cc_ext, sp_in, cc_in, sp_out, sp_oe, sp_pu;
  logic [7:0] cc_out, cc_oe, cc_pu, sp_rd, cc_rd, sp_l, cc_l, sw, cw, sx, cx, sr, cr;
  logic [4:0] cmp_en, cmp_out, cc_irq, cc_cap;
  logic srx, sdin, irq0, irq1, c0, c1, trig, c2;
  int n_errors = 0;
  int tests_run = 0;
  // rows: sp latch, cc latch, sp pulled low, cc pulled low, sp read, cc read
  logic [47:0] rows [5] = '{48'h0FF000000FF0, 48'hFFFFAA5555AA, 48'hF00F3C3CC003,
    48'h000000000000, 48'hFFFF0000FFFF};
  dpm_board sp_brd (.sys_clk(sys_clk), .pin_out(sp_out), .pin_oe(sp_oe), .pin_pullup(sp_pu),
    .ext_low(sp_ext), .pin_level(sp_in));
  dpm_board cc_brd (.sys_clk(sys_clk), .pin_out(cc_out), .pin_oe(cc_oe), .pin_pullup(cc_pu),
    .ext_low(cc_ext), .pin_level(cc_in));
  dpm_mux DUT (.sys_clk(sys_clk), .rst_b(rst_b), .sp_latch_we(sp_we), .sp_latch_wdata(sp_wd),
    .cc_latch_we(cc_we), .cc_latch_wdata(cc_wd), .serial_zero_transmit(tx),
    .serial_sync_mode(smode), .serial_sync_data_oe(soe), .serial_sync_data_out(sout),
    .mem_write_strobe_b(wr_b), .mem_read_strobe_b(rd_b), .compare_en(cmp_en),
    .compare_out(cmp_out), .system_clock_output_en(clk_en), .system_clock_output(sclk),
    .verify_mode(vmode), .verify_addr_lo(vaddr), .sp_pin_in(sp_in), .sp_pin_out(sp_out),
    .sp_pin_oe(sp_oe), .sp_pin_pullup(sp_pu), .cc_pin_in(cc_in), .cc_pin_out(cc_out),
    .cc_pin_oe(cc_oe), .cc_pin_pullup(cc_pu), .sp_pin_read(sp_rd), .cc_pin_read(cc_rd),
    .sp_latch(sp_l), .cc_latch(cc_l), .serial_zero_receive(srx), .serial_sync_data_in(sdin),
    .ext_irq0(irq0), .ext_irq1(irq1), .counter_zero_input(c0), .counter_one_input(c1),
    .cc_irq_in(cc_irq), .cc_capture_in(cc_cap), .timer_two_reload_trigger(trig),
    .counter_two_input(c2));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // reset state: latches high, pins released, gated inputs at idle
  task automatic chk_reset;
    chk({sp_out, cc_out, sp_oe, cc_oe}, 32'h00000000);
    chk({sp_l, cc_l, sp_pu, cc_pu}, 32'hFFFFFFFF);
    chk({sp_rd, cc_rd}, 16'hFFFF);
    chk({srx, sdin, irq0, irq1, cc_irq, c0, c1, trig, c2, cc_cap}, 18'h3FE00);
  endtask : chk_reset
  task automatic wr(input logic [7:0] s, input logic [7:0] c);
    @(posedge sys_clk);
    sp_we <= 1'b1;
    cc_we <= 1'b1;
    sp_wd <= s;
    cc_wd <= c;
    @(posedge sys_clk);
    sp_we <= 1'b0;
    cc_we <= 1'b0;
  endtask : wr
  // pin reads trail by up to four cycles, gated inputs one more
  task automatic settle;
    repeat (7) @(posedge sys_clk);
    #1;
  endtask : settle
  // gated inputs idle at 1 for interrupts, 0 for counters, trigger and capture
  function automatic logic [31:0] alt(logic [7:0] sl, logic [7:0] cl, logic [7:0] s,
      logic [7:0] c);
    return {15'h0000, sl[0] ? s[0] : 1'b1, sl[2] ? s[2] : 1'b1, sl[3] ? s[3] : 1'b1,
      sl[4] & s[4], sl[5] & s[5], cl[5] & c[5], cl[7] & c[7], ~cl[4:0] | c[4:0],
      cl[4:0] & c[4:0]};
  endfunction : alt
  task automatic test_done;
    $display("errors %0d, comparisons %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  // ----------------------------------------
  // stimulus
  // ----------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (5000) @(posedge sys_clk);
    n_errors++;
    test_done();
  end
  initial begin
    {rst_b, sp_we, cc_we, smode, soe, sout, clk_en, sclk, vmode} = 9'h000;
    {tx, wr_b, rd_b} = 3'h7;
    {sp_wd, cc_wd, vaddr, sp_ext, cc_ext} = 40'h0;
    {cmp_en, cmp_out} = 10'h000;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    #1;
    chk_reset();
    for (int i = 0; i < 5; i++) begin
      {sw, cw, sx, cx, sr, cr} = rows[i];
      @(posedge sys_clk);
      sp_ext <= sx;
      cc_ext <= cx;
      wr(sw, cw);
      settle();
      chk({sp_rd, cc_rd, sp_l, cc_l}, {sr, cr, sw, cw});
      chk({sp_oe, cc_oe, sp_pu & sw, cc_pu & cw}, {~sw, ~cw, sw, cw});
      chk({sp_out & sp_oe, cc_out & cc_oe}, 16'h0000);
      chk({srx, irq0, irq1, c0, c1, trig, c2, cc_irq, cc_cap}, alt(sw, cw, sr, cr));
    end
    // mid-run reset must bring zeroed latches back to all ones
    wr(8'h00, 8'h00);
    @(posedge sys_clk);
    rst_b <= 1'b0;
    #1;
    chk_reset();
    @(posedge sys_clk);
    rst_b <= 1'b1;
    settle();
    chk({sp_rd, cc_rd, sp_l, cc_l}, 32'hFFFFFFFF);
    @(posedge sys_clk);
    wr_b <= 1'b0;
    settle();
    chk({sp_oe[6], sp_out[6], sp_rd}, 10'h2BF);
    @(posedge sys_clk);
    wr_b <= 1'b1;
    rd_b <= 1'b0;
    tx <= 1'b0;
    settle();
    chk(sp_rd, 8'h7D);
    @(posedge sys_clk);
    rd_b <= 1'b1;
    tx <= 1'b1;
    smode <= 1'b1;
    soe <= 1'b1;
    settle();
    chk(sp_rd, 8'hFE);
    @(posedge sys_clk);
    sout <= 1'b1;
    settle();
    chk(sp_rd, 8'hFF);
    @(posedge sys_clk);
    soe <= 1'b0;
    settle();
    chk({sdin, sp_rd[0]}, 2'h3);
    wr(8'hFF, 8'h00);
    cmp_en <= 5'h1F;
    cmp_out <= 5'h15;
    settle();
    chk({cc_rd, cc_irq, cc_oe[4:0]}, 18'h057FF);
    wr(8'hFF, 8'hFF);
    cmp_en <= 5'h00;
    clk_en <= 1'b1;
    settle();
    chk(cc_rd, 8'hBF);
    @(posedge sys_clk);
    sclk <= 1'b1;
    settle();
    chk(cc_rd, 8'hFF);
    @(posedge sys_clk);
    vmode <= 1'b1;
    vaddr <= 8'h5A;
    cc_ext <= 8'hFF;
    settle();
    chk({cc_oe, cc_rd}, 16'hFF5A);
    test_done();
  end
endmodule : test_dual_port_alt_function_mux
